// file: rtl/tmrc_core.sv
// Two 8/13/16-bit timer/counters and a third 16-bit up/down counter.
// Assumes async pins synchronised here and one classic Wishbone master.
//
// Added by the designer: the register offsets and the Wishbone slave port.
module tmrc_core
  import tmrc_pkg::*;
// ==========================================================
// How it works
// (R1) Machine cycle is 12 or 6 clocks, chosen by the timing mode bit.
// (R2) Count pins are sampled at the sample phase; high then low counts.
// (R3) Edge needs two machine cycles, so count rate is at most clock/24, or clock/12 in 6T mode.
// (R4) Counts change at update phase; an edge counts in the next cycle.
// (R5) Mode register bit 2 picks counter for unit 0, bit 6 for unit 1.
// (R6) Timer function advances once per machine cycle, clock/12 default.
// (R7) Two mode bits per unit choose one of four modes.
// (R8) Mode 0 counts with high byte and low five bits of low byte.
// (R9) A unit counts when run is set and gate is 0 or irq pin is high.
// (R10) Mode 0 sets overflow when 1FFF wraps to 0000.
// (R11) Mode 1 counts sixteen bits, overflow on FFFF to 0000.
// (R12) Mode 2 counts low byte, reloads it from high byte on wrap.
// (R13) Unit 1 in mode 3 freezes and holds its count.
// (R14) Unit 0 mode 3 splits; low byte uses all unit 0 controls.
// (R15) Unit 0 mode 3 high byte ticks, with unit 1 run and overflow.
// (R16) Unit 1 then runs on gate and pin, without run bit or overflow.
// (R17) Unit 1 overflow is offered as a baud clock source.
// (R18) Third counter is 16-bit up/down, set by its mode register bit 0.
// (R19) Third counter uses pin when select is 1, else machine cycles (clock/12 default); needs run.
// (R20) Overflow flags clear when the processor vectors to the handler.
// (R21) External count pins stay high and low a full machine cycle each.
(
  // Clock, reset, enable
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // External pins
  input  wire tmrc_pins_t  pins_i,
  // Interrupt controller side
  input  wire logic        vec_unit0_i,
  input  wire logic        vec_unit1_i,
  output logic             ovf0_o,
  output logic             ovf1_o,
  output logic             baud_tick_o
);

  // ==========================================================
  // Storage
  logic [7:0]  mode_ff, nxt_mode;
  logic [7:0]  ctl_ff, nxt_ctl;
  logic [7:0]  lo0_ff, nxt_lo0, hi0_ff, nxt_hi0;
  logic [7:0]  lo1_ff, nxt_lo1, hi1_ff, nxt_hi1;
  logic [2:0]  t3ctl_ff, nxt_t3ctl;
  logic        t3cfg_ff, nxt_t3cfg;
  logic        six_ff, nxt_six;
  logic [15:0] cnt3_ff, nxt_cnt3;
  logic [3:0]  ph_ff, nxt_ph;
  tmrc_pins_t  s1_ff, s2_ff;
  logic [2:0]  smp_ff, nxt_smp, prv_ff, nxt_prv;
  logic [2:0]  edge_ff, nxt_edge;
  logic        ack_ff, nxt_ack;
  logic [31:0] rdat_ff, nxt_rdat;
  logic        baud_ff, nxt_baud;

  // Decoded controls
  tmrc_unit_cfg_t cfg0, cfg1;
  logic           mc_end, smp_ph, upd_ph;
  logic           en0, en1, en_hi0, tick0, tick1, tick3;
  logic           ovf_lo0, ovf_hi0, ovf1;
  logic           wr, rd_req;

  assign cfg0   = {mode_ff[TMRC_MODE_GT0], mode_ff[TMRC_MODE_CT0],
                   tmrc_mode_t'(mode_ff[1:0])};
  assign cfg1   = {mode_ff[TMRC_MODE_GT0 + TMRC_MODE_U1],
                   mode_ff[TMRC_MODE_CT1], tmrc_mode_t'(mode_ff[5:4])};

  // Last clock of a machine cycle; 12T or 6T
  // Wraps at once if the 6T mode is switched in with the phase past five
  assign mc_end = (ph_ff >= (six_ff ? TMRC_MC_6T : TMRC_MC_12T) - 4'h1);
  assign smp_ph = ce_i && (ph_ff == TMRC_PH_SMP);                // see (R2)
  assign upd_ph = ce_i && (ph_ff == TMRC_PH_UPD);                // see (R4)
  assign wr     = wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff;
  assign rd_req = wb_cyc_i && wb_stb_i && !ack_ff;

  // Byte merge under a lane strobe
  function automatic logic [7:0] lane(input logic [7:0] old,
                                      input logic [7:0] nw,
                                      input logic       s);
    lane = s ? nw : old;
  endfunction

  // Gating: run and (gate low or irq pin high)
  function automatic logic gated(input logic run, input logic gate,
                                 input logic pin);
    gated = run && (!gate || pin);                               // see (R9)
  endfunction

  // ==========================================================
  // Machine cycle phase counter
  always_comb begin
    nxt_ph = ph_ff;
    if (ce_i) begin
      nxt_ph = mc_end ? 4'h0 : ph_ff + 4'h1;                     // see (R1)
    end
  end

  // ==========================================================
  // Pin sampling; edge stays pending until the next update phase
  always_comb begin
    nxt_smp  = smp_ff;
    nxt_prv  = prv_ff;
    nxt_edge = edge_ff;
    if (upd_ph) begin
      nxt_edge = 3'h0;
    end
    if (smp_ph) begin
      nxt_prv  = smp_ff;
      nxt_smp  = {s2_ff.cnt2, s2_ff.cnt1, s2_ff.cnt0};
      // High one sample, low the next; two cycles per edge, see (R3)
      nxt_edge = smp_ff & ~{s2_ff.cnt2, s2_ff.cnt1, s2_ff.cnt0}; // see (R2)
    end
  end

  // Count ticks: timer once per machine cycle, counter on stored edge
  assign tick0  = upd_ph && (cfg0.cnt_sel ? edge_ff[0] : 1'b1); // see (R6)
  assign tick1  = upd_ph && (cfg1.cnt_sel ? edge_ff[1] : 1'b1); // see (R5)
  assign tick3  = upd_ph && t3ctl_ff[TMRC_T3_RUN] &&
                  (t3ctl_ff[TMRC_T3_CSEL] ? edge_ff[2] : 1'b1); // see (R19)

  assign en0    = gated(ctl_ff[TMRC_CTL_RUN0], cfg0.gate, s2_ff.irq0);
  // Unit 1 loses its run bit to unit 0's high byte in split mode
  assign en1    = (cfg0.mode == TMRC_MODESP)
                  ? gated(1'b1, cfg1.gate, s2_ff.irq1)          // see (R16)
                  : gated(ctl_ff[TMRC_CTL_RUN1], cfg1.gate, s2_ff.irq1);
  assign en_hi0 = ctl_ff[TMRC_CTL_RUN1];                         // see (R15)

  // ==========================================================
  // Unit counters
  always_comb begin
    nxt_lo0  = lo0_ff;
    nxt_hi0  = hi0_ff;
    nxt_lo1  = lo1_ff;
    nxt_hi1  = hi1_ff;
    ovf_lo0  = 1'b0;
    ovf_hi0  = 1'b0;
    ovf1     = 1'b0;
    if (tick0 && en0) begin
      case (cfg0.mode)
        TMRC_MODE13: begin                                       // see (R8)
          nxt_lo0 = {lo0_ff[7:5], lo0_ff[4:0] + 5'h01};
          if (lo0_ff[4:0] == 5'h1F) begin
            nxt_hi0 = hi0_ff + 8'h01;
            ovf_lo0 = (hi0_ff == 8'hFF);                         // see (R10)
          end
        end
        TMRC_MODE16: begin
          nxt_lo0 = lo0_ff + 8'h01;
          if (lo0_ff == 8'hFF) begin
            nxt_hi0 = hi0_ff + 8'h01;
            ovf_lo0 = (hi0_ff == 8'hFF);                         // see (R11)
          end
        end
        TMRC_MODE8R: begin
          nxt_lo0 = (lo0_ff == 8'hFF) ? hi0_ff : lo0_ff + 8'h01; // see (R12)
          ovf_lo0 = (lo0_ff == 8'hFF);
        end
        default: begin
          nxt_lo0 = lo0_ff + 8'h01;                              // see (R14)
          ovf_lo0 = (lo0_ff == 8'hFF);
        end
      endcase
    end
    if (cfg0.mode == TMRC_MODESP && upd_ph && en_hi0) begin
      nxt_hi0 = hi0_ff + 8'h01;                                  // see (R15)
      ovf_hi0 = (hi0_ff == 8'hFF);
    end
    if (tick1 && en1) begin
      case (cfg1.mode)
        TMRC_MODE13: begin
          nxt_lo1 = {lo1_ff[7:5], lo1_ff[4:0] + 5'h01};
          if (lo1_ff[4:0] == 5'h1F) begin
            nxt_hi1 = hi1_ff + 8'h01;
            ovf1    = (hi1_ff == 8'hFF);
          end
        end
        TMRC_MODE16: begin
          nxt_lo1 = lo1_ff + 8'h01;
          if (lo1_ff == 8'hFF) begin
            nxt_hi1 = hi1_ff + 8'h01;
            ovf1    = (hi1_ff == 8'hFF);
          end
        end
        TMRC_MODE8R: begin
          nxt_lo1 = (lo1_ff == 8'hFF) ? hi1_ff : lo1_ff + 8'h01;
          ovf1    = (lo1_ff == 8'hFF);
        end
        default: begin
          nxt_lo1 = lo1_ff;                                      // see (R13)
        end
      endcase
    end
    // Software writes lose to nothing but are taken after counting
    if (wr && wb_adr_i == TMRC_ADR_U0) begin
      nxt_lo0 = lane(nxt_lo0, wb_dat_i[7:0], wb_sel_i[0]);
      nxt_hi0 = lane(nxt_hi0, wb_dat_i[15:8], wb_sel_i[1]);
    end
    if (wr && wb_adr_i == TMRC_ADR_U1) begin
      nxt_lo1 = lane(nxt_lo1, wb_dat_i[7:0], wb_sel_i[0]);
      nxt_hi1 = lane(nxt_hi1, wb_dat_i[15:8], wb_sel_i[1]);
    end
  end

  // ==========================================================
  // Control and mode registers; overflow flags set beats clear
  always_comb begin
    nxt_mode  = mode_ff;
    nxt_ctl   = ctl_ff;
    nxt_t3ctl = t3ctl_ff;
    nxt_t3cfg = t3cfg_ff;
    nxt_six   = six_ff;
    nxt_baud  = 1'b0;
    if (wr) begin
      if (wb_adr_i == TMRC_ADR_MODE) begin
        nxt_mode = lane(mode_ff, wb_dat_i[7:0], wb_sel_i[0]);    // see (R7)
      end else if (wb_adr_i == TMRC_ADR_CTRL) begin
        nxt_ctl = lane(ctl_ff, wb_dat_i[7:0], wb_sel_i[0]);
      end else if (wb_adr_i == TMRC_ADR_T3CTL) begin
        if (wb_sel_i[0]) begin
          nxt_t3ctl = wb_dat_i[2:0];
        end
      end else if (wb_adr_i == TMRC_ADR_CFG) begin
        if (wb_sel_i[0]) begin
          nxt_t3cfg = wb_dat_i[0];                               // see (R18)
          nxt_six   = wb_dat_i[1];
        end
      end
    end
    if (vec_unit0_i) begin
      nxt_ctl[TMRC_CTL_OVF0] = 1'b0;                             // see (R20)
    end
    if (vec_unit1_i) begin
      nxt_ctl[TMRC_CTL_OVF1] = 1'b0;                             // see (R20)
    end
    if (ovf_lo0) begin
      nxt_ctl[TMRC_CTL_OVF0] = 1'b1;
    end
    // Split mode hands unit 1's flag to unit 0's high byte
    if (ovf_hi0 || (ovf1 && cfg0.mode != TMRC_MODESP)) begin
      nxt_ctl[TMRC_CTL_OVF1] = 1'b1;                             // see (R16)
    end
    if (ovf1) begin
      nxt_baud = 1'b1;                                           // see (R17)
    end
  end

  // ==========================================================
  // Third counter, up or down by its direction bit
  always_comb begin
    nxt_cnt3 = cnt3_ff;
    if (tick3) begin
      if (t3cfg_ff && !t3ctl_ff[TMRC_T3_DIR]) begin
        nxt_cnt3 = cnt3_ff - 16'h0001;                           // see (R18)
      end else begin
        nxt_cnt3 = cnt3_ff + 16'h0001;
      end
    end
    if (wr && wb_adr_i == TMRC_ADR_T3CNT) begin
      nxt_cnt3[7:0]  = lane(nxt_cnt3[7:0], wb_dat_i[7:0], wb_sel_i[0]);
      nxt_cnt3[15:8] = lane(nxt_cnt3[15:8], wb_dat_i[15:8], wb_sel_i[1]);
    end
  end

  // ==========================================================
  // Bus answer: one wait-free ack; unmapped reads return zero
  always_comb begin
    nxt_ack  = rd_req;
    nxt_rdat = 32'h0000_0000;
    if (wb_adr_i == TMRC_ADR_MODE) begin
      nxt_rdat[7:0] = mode_ff;
    end else if (wb_adr_i == TMRC_ADR_CTRL) begin
      nxt_rdat[7:0] = ctl_ff;
    end else if (wb_adr_i == TMRC_ADR_U0) begin
      nxt_rdat[15:0] = {hi0_ff, lo0_ff};
    end else if (wb_adr_i == TMRC_ADR_U1) begin
      nxt_rdat[15:0] = {hi1_ff, lo1_ff};
    end else if (wb_adr_i == TMRC_ADR_T3CTL) begin
      nxt_rdat[2:0] = t3ctl_ff;
    end else if (wb_adr_i == TMRC_ADR_T3CNT) begin
      nxt_rdat[15:0] = cnt3_ff;
    end else if (wb_adr_i == TMRC_ADR_CFG) begin
      nxt_rdat[1:0] = {six_ff, t3cfg_ff};
    end
  end

  // ==========================================================
  // Registers; pins take two flops first
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s1_ff    <= '0;
      s2_ff    <= '0;
    end else begin
      s1_ff    <= pins_i;
      s2_ff    <= s1_ff;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mode_ff  <= TMRC_RST_BYTE;
      ctl_ff   <= TMRC_RST_BYTE;
      lo0_ff   <= TMRC_RST_BYTE;
      hi0_ff   <= TMRC_RST_BYTE;
      lo1_ff   <= TMRC_RST_BYTE;
      hi1_ff   <= TMRC_RST_BYTE;
      t3ctl_ff <= 3'h0;
      t3cfg_ff <= 1'b0;
      six_ff   <= 1'b0;
      cnt3_ff  <= TMRC_RST_WORD;
      ph_ff    <= 4'h0;
      smp_ff   <= 3'h0;
      prv_ff   <= 3'h0;
      edge_ff  <= 3'h0;
      ack_ff   <= 1'b0;
      rdat_ff  <= 32'h0000_0000;
      baud_ff  <= 1'b0;
    end else if (ce_i) begin
      mode_ff  <= nxt_mode;
      ctl_ff   <= nxt_ctl;
      lo0_ff   <= nxt_lo0;
      hi0_ff   <= nxt_hi0;
      lo1_ff   <= nxt_lo1;
      hi1_ff   <= nxt_hi1;
      t3ctl_ff <= nxt_t3ctl;
      t3cfg_ff <= nxt_t3cfg;
      six_ff   <= nxt_six;
      cnt3_ff  <= nxt_cnt3;
      ph_ff    <= nxt_ph;
      smp_ff   <= nxt_smp;
      prv_ff   <= nxt_prv;
      edge_ff  <= nxt_edge;
      ack_ff   <= nxt_ack;
      rdat_ff  <= nxt_rdat;
      baud_ff  <= nxt_baud;
    end
  end

  assign wb_dat_o    = rdat_ff;
  assign wb_ack_o    = ack_ff;
  assign ovf0_o      = ctl_ff[TMRC_CTL_OVF0];
  assign ovf1_o      = ctl_ff[TMRC_CTL_OVF1];
  assign baud_tick_o = baud_ff;

  // ==========================================================
  // Checks
  p_phase_wrap: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && !six_ff |-> ph_ff < TMRC_MC_12T)
    else $error("phase past twelve");                            // see (R1)
  property p_edge_once;
    @(posedge mclk_i) disable iff (rst_i)
    ce_i && smp_ph |=> ##1 !(edge_ff[0] && !prv_ff[0]);
  endproperty
  a_edge_once: assert property (p_edge_once)
    else $error("edge without prior high");                      // see (R2)
  property p_ovf0_set;
    @(posedge mclk_i) disable iff (rst_i)
    ce_i && ovf_lo0 |=> ovf0_o;
  endproperty
  a_ovf0_set: assert property (p_ovf0_set)
    else $error("overflow 0 flag not set");                      // see (R10)
  property p_reload;
    @(posedge mclk_i) disable iff (rst_i)
    ce_i && tick0 && en0 && cfg0.mode == TMRC_MODE8R && lo0_ff == 8'hFF
      && !wr |=> lo0_ff == $past(hi0_ff) && hi0_ff == $past(hi0_ff);
  endproperty
  a_reload: assert property (p_reload)
    else $error("mode 2 reload wrong");                          // see (R12)
  property p_freeze;
    @(posedge mclk_i) disable iff (rst_i)
    ce_i && cfg1.mode == TMRC_MODESP && !wr |=> $stable(lo1_ff);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("unit 1 not frozen");                            // see (R13)
  property p_clear;
    @(posedge mclk_i) disable iff (rst_i)
    ce_i && vec_unit0_i && !ovf_lo0 |=> !ovf0_o;
  endproperty
  a_clear: assert property (p_clear)
    else $error("overflow 0 not cleared");                       // see (R20)
  property p_ack;
    @(posedge mclk_i) disable iff (rst_i)
    ce_i && wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("ack held two cycles");
  property p_t3hold;
    @(posedge mclk_i) disable iff (rst_i)
    ce_i && !t3ctl_ff[TMRC_T3_RUN] && !wr |=> $stable(cnt3_ff);
  endproperty
  a_t3hold: assert property (p_t3hold)
    else $error("third counter ran while stopped");              // see (R19)

endmodule

// file: rtl/tmrc_pkg.sv
// Package for the dual timer/counter core with a third up/down counter.
// Assumes a single 100 MHz clock and a classic Wishbone register bus.
package tmrc_pkg;

  // ==========================================================
  // Register byte addresses
  localparam logic [4:0] TMRC_ADR_MODE   = 5'h00;
  localparam logic [4:0] TMRC_ADR_CTRL   = 5'h04;
  localparam logic [4:0] TMRC_ADR_U0     = 5'h08;
  localparam logic [4:0] TMRC_ADR_U1     = 5'h0C;
  localparam logic [4:0] TMRC_ADR_T3CTL  = 5'h10;
  localparam logic [4:0] TMRC_ADR_T3CNT  = 5'h14;
  localparam logic [4:0] TMRC_ADR_CFG    = 5'h18;

  // ==========================================================
  // Mode register field positions (unit 1 sits four bits higher)
  localparam int TMRC_MODE_M0   = 0;
  localparam int TMRC_MODE_M1   = 1;
  localparam int TMRC_MODE_CT0  = 2;
  localparam int TMRC_MODE_GT0  = 3;
  localparam int TMRC_MODE_CT1  = 6;
  localparam int TMRC_MODE_U1   = 4;

  // Control register field positions
  localparam int TMRC_CTL_RUN0  = 4;
  localparam int TMRC_CTL_OVF0  = 5;
  localparam int TMRC_CTL_RUN1  = 6;
  localparam int TMRC_CTL_OVF1  = 7;

  // Third counter control and configuration bits
  localparam int TMRC_T3_RUN    = 2;
  localparam int TMRC_T3_CSEL   = 1;
  localparam int TMRC_T3_DIR    = 0;

  // Reset values
  localparam logic [7:0]  TMRC_RST_BYTE = 8'h00;
  localparam logic [15:0] TMRC_RST_WORD = 16'h0000;

  // ==========================================================
  // Machine cycle timing
  localparam logic [3:0] TMRC_MC_12T   = 4'hC;
  localparam logic [3:0] TMRC_MC_6T    = 4'h6;
  localparam logic [3:0] TMRC_PH_UPD   = 4'h2;
  localparam logic [3:0] TMRC_PH_SMP   = 4'h3;

  // Mode encoding
  typedef enum logic [1:0] {
    TMRC_MODE13 = 2'h0,
    TMRC_MODE16 = 2'h1,
    TMRC_MODE8R = 2'h2,
    TMRC_MODESP = 2'h3
  } tmrc_mode_t;

  // One unit's configuration
  typedef struct packed {
    logic       gate;
    logic       cnt_sel;
    tmrc_mode_t mode;
  } tmrc_unit_cfg_t;

  // Pin group
  typedef struct packed {
    logic cnt0;
    logic cnt1;
    logic cnt2;
    logic irq0;
    logic irq1;
  } tmrc_pins_t;

endpackage

// file: verification/tmrc_far.sv
// Far-side model: count pins, gate pins and interrupt controller.
// Assumes the core's clock; pin levels change just after rising edges.
module tmrc_far
  import tmrc_pkg::*;
(
  // Clock
  input  wire logic mclk_i,
  // Core flags and vector enable
  input  wire logic ovf0_i,
  input  wire logic ovf1_i,
  input  wire logic vec_en_i,
  // Pins and vectors
  output tmrc_pins_t pins_o,
  output logic       vec0_o,
  output logic       vec1_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int n_vec = 0;

  // Idle pins rest low; no pull level is given for them
  initial begin
    pins_o = '0;
  end

  // ====================
  // Interrupt controller: one vector per raised flag
  always @(posedge mclk_i) begin
    vec0_o <= vec_en_i & ovf0_i & ~vec0_o;
    vec1_o <= vec_en_i & ovf1_i & ~vec1_o;
    n_vec  <= n_vec + int'(vec0_o) + int'(vec1_o);
  end

  // ====================
  // Pin levels
  task automatic set(input int s, input logic v);
    case (s)
      0: pins_o.cnt0 <= v;
      1: pins_o.cnt1 <= v;
      2: pins_o.cnt2 <= v;
      3: pins_o.irq0 <= v;
      default: pins_o.irq1 <= v;
    endcase
  endtask

  // Each level held per clocks, never below one machine cycle
  task automatic pulses(input int s, input int n, input int per);
    repeat (n) begin
      set(s, 1'b1);
      repeat (per) @(posedge mclk_i);
      set(s, 1'b0);
      repeat (per) @(posedge mclk_i);
    end
  endtask
endmodule

// file: verification/test_timer_counter_0_1_core.sv
// Self-checking bench for the dual timer/counter core.
// Assumes tmrc_far on the pins and a classic Wishbone master here.
module test_timer_counter_0_1_core;
  import tmrc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int K = 20;
  logic        mclk_i = 1'b0;
  logic        rst_i  = 1'b1;
  logic        ce_i   = 1'b1;
  logic        cyc    = 1'b0;
  logic        stb    = 1'b0;
  logic        we     = 1'b0;
  logic        vec_en = 1'b0;
  logic [4:0]  adr    = 5'h00;
  logic [31:0] wdat   = 32'h0;
  logic [31:0] rdat, rd_q;
  logic        ack, ovf0, ovf1, baud, v0, v1;
  logic [15:0] a, b;
  tmrc_pins_t  pins;
  int          n_fail = 0;
  int          tests_run = 0;
  int          cyc_n = 0;
  int          n_baud = 0;
  int          nb;
  int          mc = 12;

  always #5 mclk_i = ~mclk_i;

  tmrc_core dut_u (
    .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .pins_i(pins), .vec_unit0_i(v0), .vec_unit1_i(v1),
    .ovf0_o(ovf0), .ovf1_o(ovf1), .baud_tick_o(baud)
  );
  tmrc_far far_u (
    .mclk_i(mclk_i), .ovf0_i(ovf0), .ovf1_i(ovf1), .vec_en_i(vec_en),
    .pins_o(pins), .vec0_o(v0), .vec1_o(v1)
  );

  // ====================
  // Checks and bus cycles
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [4:0] ad,
                     input logic [31:0] d);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= ad;
    wdat <= d;
    @(posedge mclk_i);
    // Only the bench timeout ends a wait that never sees ack
    while (ack !== 1'b1) begin
      @(posedge mclk_i);
    end
    rd_q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge mclk_i);
  endtask

  // Reads spaced by exactly K machine cycles
  task automatic meas(input logic [4:0] ad, output logic [15:0] x,
                      output logic [15:0] y);
    bus(1'b0, ad, 32'h0);
    x = rd_q[15:0];
    repeat (mc * K - 3) @(posedge mclk_i);
    bus(1'b0, ad, 32'h0);
    y = rd_q[15:0];
  endtask

  // ====================
  // Reference model: k ticks of one unit
  function automatic logic [15:0] adv(input int u, input int md,
      input logic [15:0] v, input int k, inout int ov);
    logic [12:0] c;
    for (int i = 0; i < k; i++) begin
      case (md)
        0: begin
          c = {v[15:8], v[4:0]} + 13'h1;
          ov += int'(c == 13'h0);
          v = {c[12:5], v[7:5], c[4:0]};
        end
        1: begin
          v = v + 16'h1;
          ov += int'(v == 16'h0);
        end
        2: begin
          ov += int'(v[7:0] == 8'hFF);
          v[7:0] = (v[7:0] == 8'hFF) ? v[15:8] : v[7:0] + 8'h1;
        end
        default: begin
          if (u == 0) begin
            v[7:0] = v[7:0] + 8'h1;
            ov += int'(v[7:0] == 8'h0);
          end
        end
      endcase
    end
    return v;
  endfunction

  // Start near wrap, run, compare count and flag
  task automatic tmr(input int u, input logic [7:0] mreg, input int ke);
    int md, ov;
    logic [15:0] v, x, y, m;
    logic [4:0] ad;
    md = int'((mreg >> (4 * u)) & 8'h03);
    ad = u ? TMRC_ADR_U1 : TMRC_ADR_U0;
    ov = 0;
    v = {(md == 2) ? 8'($urandom) : 8'hFF, 8'hFF - 8'($urandom_range(15, 4))};
    m = (md == 0) ? 16'hFF1F : 16'hFFFF;
    bus(1'b1, TMRC_ADR_CTRL, 32'h0);
    bus(1'b1, TMRC_ADR_MODE, {24'h0, mreg});
    bus(1'b1, ad, {16'h0, v});
    bus(1'b1, TMRC_ADR_CTRL, 32'h1 << (TMRC_CTL_RUN0 + 2 * u));
    meas(ad, x, y);
    chk(y & m, adv(u, md, x, ke, ov) & m);
    bus(1'b0, TMRC_ADR_CTRL, 32'h0);
    chk(rd_q[TMRC_CTL_OVF0 + 2 * u], ov != 0 && !vec_en);
  endtask

  // Falling edges from the far side
  task automatic cnt(input int s, input int per, input int n);
    logic [4:0] ad;
    logic [15:0] x;
    ad = (s == 0) ? TMRC_ADR_U0 : (s == 1) ? TMRC_ADR_U1 : TMRC_ADR_T3CNT;
    bus(1'b0, ad, 32'h0);
    x = rd_q[15:0];
    far_u.pulses(s, n, per);
    repeat (40) @(posedge mclk_i);
    bus(1'b0, ad, 32'h0);
    chk(16'(rd_q[15:0] - x), n);
  endtask

  task automatic t3(input logic [31:0] cf, input logic [31:0] ct,
                    input logic [15:0] e);
    bus(1'b1, TMRC_ADR_CFG, cf);
    bus(1'b1, TMRC_ADR_T3CTL, ct);
    meas(TMRC_ADR_T3CNT, a, b);
    chk(16'(b - a), e);
  endtask

  // ====================
  // Timeout, sized well above the expected run
  always @(posedge mclk_i) begin
    cyc_n <= cyc_n + 1;
    if (baud === 1'b1) begin
      n_baud <= n_baud + 1;
    end
    if (cyc_n == 60000) begin
      n_fail++;
      end_sim();
    end
  end

  initial begin
    void'($urandom(11));
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    // Unmapped write ignored; all places read zero
    bus(1'b1, 5'h1C, 32'hFFFF_FFFF);
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, 5'(4 * i), 32'h0);
      chk(rd_q, 32'h0);
    end
    for (int u = 0; u < 2; u++) begin
      for (int md = 0; md < 4; md++) begin
        tmr(u, 8'(md << (4 * u)), K);
      end
      tmr(u, 8'(8'h09 << (4 * u)), 0);
      far_u.set(3 + u, 1'b1);
      tmr(u, 8'(8'h09 << (4 * u)), K);
    end
    // Split unit 0 with run1 only; unit 1 runs with no run bit
    bus(1'b1, TMRC_ADR_CTRL, 32'h0);
    bus(1'b1, TMRC_ADR_MODE, 32'h13);
    bus(1'b1, TMRC_ADR_U0, 32'h1234);
    bus(1'b1, TMRC_ADR_U1, 32'hFFF8);
    nb = n_baud;
    bus(1'b1, TMRC_ADR_CTRL, 32'h40);
    meas(TMRC_ADR_U0, a, b);
    chk(16'(b - a), 16'(K * 256));
    meas(TMRC_ADR_U1, a, b);
    chk(16'(b - a), K);
    chk(n_baud - nb, 1);
    bus(1'b0, TMRC_ADR_CTRL, 32'h0);
    chk(rd_q[7:0], 8'h40);
    // Pin counting at full rate and slowly
    bus(1'b1, TMRC_ADR_MODE, 32'h55);
    bus(1'b1, TMRC_ADR_CTRL, 32'h50);
    bus(1'b1, TMRC_ADR_T3CTL, 32'h7);
    for (int s = 0; s < 3; s++) begin
      cnt(s, 12, 9);
      cnt(s, 29, 5);
    end
    // Vectoring clears the flags
    vec_en <= 1'b1;
    tmr(0, 8'h01, K);
    tmr(1, 8'h10, K);
    chk(far_u.n_vec, 2);
    t3(32'h0, 32'h5, 16'(K));
    // Clock enable low freezes the running third counter
    bus(1'b0, TMRC_ADR_T3CNT, 32'h0);
    a = rd_q[15:0];
    ce_i <= 1'b0;
    repeat (mc * K) @(posedge mclk_i);
    ce_i <= 1'b1;
    repeat (mc * K - 3) @(posedge mclk_i);
    bus(1'b0, TMRC_ADR_T3CNT, 32'h0);
    chk(16'(rd_q[15:0] - a), 16'(K));
    t3(32'h1, 32'h4, 16'(-K));
    t3(32'h0, 32'h1, 16'h0);
    mc = 6;
    t3(32'h2, 32'h5, 16'(K));
    tmr(0, 8'h01, K);
    end_sim();
  end
endmodule
